// [fnd_pkg.sv]
// Purpose: shared constants for the fractional-N feedback divider control
// Assumes: registers written through a decoded word port from the serial front end
// Notes: register offsets are word indices of the main bank
package fnd_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 24;
	localparam int INT_W = 19;
	localparam int FRAC_W = 24;
	localparam int NDIV_W = 20;
	localparam int RDIV_W = 14;
	localparam int EXACT_W = 14;
	localparam int ODIV_W = 6;
	localparam int FWD_ADDR_W = 3;
	localparam int FWD_DATA_W = 9;

	localparam logic [ADDR_W-1:0] OFS_REF_DIV = 5'h02;
	localparam logic [ADDR_W-1:0] OFS_INT = 5'h03;
	localparam logic [ADDR_W-1:0] OFS_FRAC = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_FWD = 5'h05;
	localparam logic [ADDR_W-1:0] OFS_MOD_CFG = 5'h06;
	localparam logic [ADDR_W-1:0] OFS_EXACT = 5'h0C;

	// modulator configuration fields
	localparam int CFG_FRAC_EN_BIT = 11;
	localparam int CFG_BYPASS_BIT = 7;
	localparam int CFG_SEED_LSB = 0;
	localparam int CFG_W = 12;

	// forwarding word: subsystem address low, data above
	localparam int FWD_ADDR_LSB = 0;
	localparam int FWD_DATA_LSB = 3;
	localparam logic [FWD_ADDR_W-1:0] OSC_OUT_DIV_ADDR = 3'h2;

	// reset values
	localparam logic [RDIV_W-1:0] RST_REF_DIV = 14'h0001;
	localparam logic [INT_W-1:0] RST_INT = 19'h0_0019;
	localparam logic [FRAC_W-1:0] RST_FRAC = 24'h00_0000;
	localparam logic [CFG_W-1:0] RST_MOD_CFG = 12'h0082;
	localparam logic [EXACT_W-1:0] RST_EXACT = 14'h0000;
	localparam logic [ODIV_W-1:0] RST_OUT_DIV = 6'h01;

	// divide ranges
	localparam logic [INT_W-1:0] INT_MODE_MIN = 19'h0_0010;
	localparam logic [INT_W-1:0] INT_MODE_MAX = 19'h7_FFFF;
	localparam logic [INT_W-1:0] FRAC_MODE_MIN = 19'h0_0014;
	localparam logic [INT_W-1:0] FRAC_MODE_MAX = 19'h7_FFFC;
	localparam logic [ODIV_W-1:0] OUT_DIV_MAX = 6'h3E;

	// accumulator start phases selected by the seed field
	localparam logic [FRAC_W-1:0] SEED_PHASE_0 = 24'h00_0000;
	localparam logic [FRAC_W-1:0] SEED_PHASE_1 = 24'h80_0000;
	localparam logic [FRAC_W-1:0] SEED_PHASE_2 = 24'h5A_3C96;
	localparam logic [FRAC_W-1:0] SEED_PHASE_3 = 24'h2B_71D4;
endpackage : fnd_pkg

// [fnd_modulator.sv]
// Purpose: per-comparison divide value generator with binary and exact modes
// Assumes: advanced once per phase-detector comparison strobe
// Notes: full 24-bit modulus always kept; exact mode re-phases every step count
`timescale 1ns/1ps
module fnd_modulator (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic tick_i,
	input wire logic load_i,
	input wire logic frac_mode_i,
	input wire logic [fnd_pkg::INT_W-1:0] int_i,
	input wire logic [fnd_pkg::FRAC_W-1:0] frac_i,
	input wire logic [fnd_pkg::EXACT_W-1:0] exact_i,
	input wire logic [1:0] seed_i,
	output logic [fnd_pkg::NDIV_W-1:0] ndiv_o
);
	import fnd_pkg::*;

	logic [INT_W-1:0] int_q, int_d;
	logic [FRAC_W-1:0] frac_q, frac_d;
	logic [FRAC_W-1:0] acc_q, acc_d;
	logic [EXACT_W-1:0] cnt_q, cnt_d;
	logic [NDIV_W-1:0] ndiv_q, ndiv_d;
	logic [FRAC_W:0] sum;
	logic [FRAC_W-1:0] seed_phase;
	logic exact_mode;
	logic period_end;

	function automatic logic [FRAC_W-1:0] seed_lut(input logic [1:0] sel);
		unique case (sel)
			2'd0: seed_lut = SEED_PHASE_0;
			2'd1: seed_lut = SEED_PHASE_1;
			2'd2: seed_lut = SEED_PHASE_2;
			2'd3: seed_lut = SEED_PHASE_3;
		endcase
	endfunction : seed_lut

	assign seed_phase = seed_lut(seed_i);
	// fixed 2^24 modulus, carry is the fractional step
	assign sum = {1'b0, acc_q} + {1'b0, frac_q};
	assign exact_mode = frac_mode_i && (exact_i != '0);
	assign period_end = exact_mode && (cnt_q + 14'h0001 >= exact_i);

	always_comb begin
		int_d = int_q;
		frac_d = frac_q;
		acc_d = acc_q;
		cnt_d = cnt_q;
		ndiv_d = ndiv_q;
		if (tick_i && load_i) begin
			int_d = int_i;
			frac_d = frac_i;
			acc_d = seed_phase;
			cnt_d = '0;
			ndiv_d = {1'b0, int_i};
		end else if (tick_i && frac_mode_i) begin
			ndiv_d = {1'b0, int_q} + {{(NDIV_W-1){1'b0}}, sum[FRAC_W]};
			acc_d = sum[FRAC_W-1:0];
			cnt_d = cnt_q + 14'h0001;
			// rephase after exact step count, exact carries per period
			if (period_end) begin
				acc_d = seed_phase;
				cnt_d = '0;
			end
		end else if (tick_i) begin
			ndiv_d = {1'b0, int_q};
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			int_q <= RST_INT;
			frac_q <= RST_FRAC;
			acc_q <= SEED_PHASE_0;
			cnt_q <= '0;
			ndiv_q <= {1'b0, RST_INT};
		end else begin
			int_q <= int_d;
			frac_q <= frac_d;
			acc_q <= acc_d;
			cnt_q <= cnt_d;
			ndiv_q <= ndiv_d;
		end
	end

	assign ndiv_o = ndiv_q;
endmodule : fnd_modulator

// [fnd_ctrl.sv]
// Purpose: register bank, reference divider and divide-ratio control
// Assumes: serial front end presents decoded word writes and reads
// Notes: ref_in_i is asynchronous and synchronised before use
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Contract
// - integer mode accepts ratios 16 to 2^19-1 with modulator off.
// - output divider is 1 for fundamental or 2 to 62 from field.
// - oscillator subsystem written only through forwarding register 0x05.
// - fractional mode integer value lies between 20 and 524,284.
// - fractional part equals fractional register over 2^24.
// - reference divided by reference divider ratio gives compare rate.
// - oscillator equals compare rate times integer plus fraction.
// - fixed binary modulus, step equals compare rate over 2^24.
// - exact mode keeps the full 24-bit accumulator modulus.
// - exact register holds steps per integer interval, below 2^14.
// - exact mode yields target frequency without quantization error.
// - new fractional frequency reloads accumulator start phase from seed.
module fnd_ctrl (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic ref_in_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [fnd_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [fnd_pkg::DATA_W-1:0] reg_wdata_i,
	output logic [fnd_pkg::DATA_W-1:0] reg_rdata_o,
	output logic pd_tick_o,
	output logic [fnd_pkg::NDIV_W-1:0] ndiv_o,
	output logic frac_mode_o,
	output logic range_err_o,
	output logic fwd_valid_o,
	output logic [fnd_pkg::FWD_ADDR_W-1:0] fwd_addr_o,
	output logic [fnd_pkg::FWD_DATA_W-1:0] fwd_data_o,
	output logic [fnd_pkg::ODIV_W-1:0] out_div_o
);
	import fnd_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// register bank
	logic [RDIV_W-1:0] ref_div_q, ref_div_d;
	logic [INT_W-1:0] int_q, int_d;
	logic [FRAC_W-1:0] frac_q, frac_d;
	logic [CFG_W-1:0] cfg_q, cfg_d;
	logic [EXACT_W-1:0] exact_q, exact_d;
	logic [FWD_ADDR_W+FWD_DATA_W-1:0] fwd_q, fwd_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic wr_ref, wr_int, wr_frac, wr_fwd, wr_cfg, wr_exact;
	logic frac_mode;

	assign wr_ref = reg_wr_i && (reg_addr_i == OFS_REF_DIV);
	assign wr_int = reg_wr_i && (reg_addr_i == OFS_INT);
	assign wr_frac = reg_wr_i && (reg_addr_i == OFS_FRAC);
	assign wr_fwd = reg_wr_i && (reg_addr_i == OFS_FWD);
	assign wr_cfg = reg_wr_i && (reg_addr_i == OFS_MOD_CFG);
	assign wr_exact = reg_wr_i && (reg_addr_i == OFS_EXACT);

	assign ref_div_d = wr_ref ? reg_wdata_i[RDIV_W-1:0] : ref_div_q;
	assign int_d = wr_int ? reg_wdata_i[INT_W-1:0] : int_q;
	assign frac_d = wr_frac ? reg_wdata_i[FRAC_W-1:0] : frac_q;
	assign cfg_d = wr_cfg ? reg_wdata_i[CFG_W-1:0] : cfg_q;
	// step count limited to 14 bits
	assign exact_d = wr_exact ? reg_wdata_i[EXACT_W-1:0] : exact_q;
	assign fwd_d = wr_fwd ? reg_wdata_i[FWD_ADDR_W+FWD_DATA_W-1:0] : fwd_q;

	// modulator in path only when enabled and not bypassed
	assign frac_mode = cfg_q[CFG_FRAC_EN_BIT] && !cfg_q[CFG_BYPASS_BIT];

	always_comb begin
		rdata_d = rdata_q;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				OFS_REF_DIV: rdata_d = {{(DATA_W-RDIV_W){1'b0}}, ref_div_q};
				OFS_INT: rdata_d = {{(DATA_W-INT_W){1'b0}}, int_q};
				OFS_FRAC: rdata_d = frac_q;
				OFS_FWD: rdata_d = {{(DATA_W-FWD_ADDR_W-FWD_DATA_W){1'b0}}, fwd_q};
				OFS_MOD_CFG: rdata_d = {{(DATA_W-CFG_W){1'b0}}, cfg_q};
				OFS_EXACT: rdata_d = {{(DATA_W-EXACT_W){1'b0}}, exact_q};
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			ref_div_q <= RST_REF_DIV;
			int_q <= RST_INT;
			frac_q <= RST_FRAC;
			cfg_q <= RST_MOD_CFG;
			exact_q <= RST_EXACT;
			fwd_q <= '0;
			rdata_q <= '0;
		end else begin
			ref_div_q <= ref_div_d;
			int_q <= int_d;
			frac_q <= frac_d;
			cfg_q <= cfg_d;
			exact_q <= exact_d;
			fwd_q <= fwd_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign frac_mode_o = frac_mode;

	////////////////////////////////////////////////////////////////////////////
	// reference path
	logic ref_s1_q, ref_s2_q, ref_s3_q;
	logic [RDIV_W-1:0] ref_cnt_q, ref_cnt_d;
	logic ref_edge, tick;
	logic [RDIV_W-1:0] ref_ratio;

	assign ref_edge = ref_s2_q && !ref_s3_q;
	assign ref_ratio = (ref_div_q == '0) ? RST_REF_DIV : ref_div_q;
	// one compare strobe per ratio reference edges
	assign tick = ref_edge && (ref_cnt_q + 14'h0001 >= ref_ratio);
	assign ref_cnt_d = !ref_edge ? ref_cnt_q : (tick ? '0 : ref_cnt_q + 14'h0001);

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			ref_s1_q <= 1'b0;
			ref_s2_q <= 1'b0;
			ref_s3_q <= 1'b0;
			ref_cnt_q <= '0;
		end else begin
			ref_s1_q <= ref_in_i;
			ref_s2_q <= ref_s1_q;
			ref_s3_q <= ref_s2_q;
			ref_cnt_q <= ref_cnt_d;
		end
	end

	assign pd_tick_o = tick;

	////////////////////////////////////////////////////////////////////////////
	// ratio staging and range limits
	logic pend_q, pend_d;
	logic commit;
	logic [INT_W-1:0] int_lim;

	function automatic logic [INT_W-1:0] limit(input logic [INT_W-1:0] v,
			input logic [INT_W-1:0] lo, input logic [INT_W-1:0] hi);
		if (v < lo)
			limit = lo;
		else if (v > hi)
			limit = hi;
		else
			limit = v;
	endfunction : limit

	// integer value held to the mode's legal range
	assign int_lim = frac_mode ? limit(int_q, FRAC_MODE_MIN, FRAC_MODE_MAX)
		: limit(int_q, INT_MODE_MIN, INT_MODE_MAX);
	assign range_err_o = (int_lim != int_q);

	// pair applied at one compare boundary
	assign commit = tick && pend_q;
	assign pend_d = wr_frac || wr_int || wr_cfg || wr_exact || (pend_q && !commit);

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i)
			pend_q <= 1'b1;
		else
			pend_q <= pend_d;
	end

	fnd_modulator u_mod (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.tick_i(tick),
		.load_i(commit),
		.frac_mode_i(frac_mode),
		.int_i(int_lim),
		.frac_i(frac_q),
		.exact_i(exact_q),
		.seed_i(cfg_q[CFG_SEED_LSB+1:CFG_SEED_LSB]),
		.ndiv_o(ndiv_o)
	);

	////////////////////////////////////////////////////////////////////////////
	// oscillator subsystem forwarding
	logic fwd_valid_q;
	logic [FWD_ADDR_W-1:0] fwd_addr_q;
	logic [FWD_DATA_W-1:0] fwd_data_q;
	logic [ODIV_W-1:0] out_div_q, out_div_d, odiv_field;

	assign odiv_field = fwd_d[FWD_DATA_LSB+ODIV_W-1:FWD_DATA_LSB];
	// 0 or 1 means fundamental, above 62 held at 62
	assign out_div_d = !(wr_fwd && fwd_d[FWD_ADDR_W-1:0] == OSC_OUT_DIV_ADDR) ? out_div_q
		: (odiv_field < 6'h02) ? RST_OUT_DIV
		: (odiv_field > OUT_DIV_MAX) ? OUT_DIV_MAX : odiv_field;

	// subsystem reached only by forwarding writes
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			fwd_valid_q <= 1'b0;
			fwd_addr_q <= '0;
			fwd_data_q <= '0;
			out_div_q <= RST_OUT_DIV;
		end else begin
			fwd_valid_q <= wr_fwd;
			fwd_addr_q <= wr_fwd ? fwd_d[FWD_ADDR_W-1:0] : fwd_addr_q;
			fwd_data_q <= wr_fwd ? fwd_d[FWD_DATA_LSB+FWD_DATA_W-1:FWD_DATA_LSB] : fwd_data_q;
			out_div_q <= out_div_d;
		end
	end

	assign fwd_valid_o = fwd_valid_q;
	assign fwd_addr_o = fwd_addr_q;
	assign fwd_data_o = fwd_data_q;
	assign out_div_o = out_div_q;
endmodule : fnd_ctrl

// [fnd_ctrl_assertions.sv]
// Purpose: port-level properties of the divider control block
// Assumes: one clock, reset held low for two or more edges
// Notes: bound onto every fnd_ctrl instance
`timescale 1ns/1ps
module fnd_ctrl_chk (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic reg_wr_i,
	input wire logic [fnd_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [fnd_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic pd_tick_o,
	input wire logic [fnd_pkg::NDIV_W-1:0] ndiv_o,
	input wire logic fwd_valid_o,
	input wire logic [fnd_pkg::FWD_ADDR_W-1:0] fwd_addr_o,
	input wire logic [fnd_pkg::FWD_DATA_W-1:0] fwd_data_o,
	input wire logic [fnd_pkg::ODIV_W-1:0] out_div_o
);
	import fnd_pkg::*;
	logic [11:0] wd_q;
	wire fwd_wr = reg_wr_i && reg_addr_i == OFS_FWD;
	always_ff @(posedge sys_clk_i) begin
		wd_q <= reg_wdata_i[11:0];
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	////////////////////////////////////////
	property p_fwd_word; fwd_wr |=> fwd_valid_o && {fwd_data_o, fwd_addr_o} == wd_q; endproperty
	a_fwd_word: assert property (p_fwd_word) else $error("forward word lost");
	property p_fwd_cause; fwd_valid_o |-> $past(fwd_wr); endproperty
	a_fwd_cause: assert property (p_fwd_cause) else $error("forward without write");
	property p_fwd_hold; !fwd_wr |=> $stable(fwd_addr_o) && $stable(fwd_data_o); endproperty
	a_fwd_hold: assert property (p_fwd_hold) else $error("forward word moved");
	property p_odiv_rng; out_div_o != 6'h00 && out_div_o <= OUT_DIV_MAX; endproperty
	a_odiv_rng: assert property (p_odiv_rng) else $error("output divider out of range");
	property p_odiv_src; $changed(out_div_o) |-> fwd_valid_o && fwd_addr_o == OSC_OUT_DIV_ADDR;
	endproperty
	a_odiv_src: assert property (p_odiv_src) else $error("output divider changed alone");
	property p_tick_gap; pd_tick_o |=> !pd_tick_o; endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("compare strobe too long");
	property p_ndiv_hold; !pd_tick_o |=> $stable(ndiv_o); endproperty
	a_ndiv_hold: assert property (p_ndiv_hold) else $error("ratio moved between strobes");
	property p_ndiv_min; ndiv_o >= INT_MODE_MIN; endproperty
	a_ndiv_min: assert property (p_ndiv_min) else $error("ratio below minimum");
	property p_ndiv_max; ndiv_o <= 20'h7_FFFF; endproperty
	a_ndiv_max: assert property (p_ndiv_max) else $error("ratio above maximum");
endmodule : fnd_ctrl_chk

bind fnd_ctrl fnd_ctrl_chk i_fnd_ctrl_chk (.sys_clk_i, .resetn_i, .reg_wr_i, .reg_addr_i,
	.reg_wdata_i, .pd_tick_o, .ndiv_o, .fwd_valid_o, .fwd_addr_o, .fwd_data_o, .out_div_o);

// [fnd_ref_model.sv]
// Purpose: reference oscillator and oscillator subsystem register sink
// Assumes: reference runs free, unrelated in phase to the system clock
// Notes: subsystem words are only reachable through forwarded writes
`timescale 1ns/1ps
module fnd_ref_model #(
	parameter int HALF_NS = 100
) (
	input wire logic sys_clk_i,
	input wire logic fwd_valid_i,
	input wire logic [fnd_pkg::FWD_ADDR_W-1:0] fwd_addr_i,
	input wire logic [fnd_pkg::FWD_DATA_W-1:0] fwd_data_i,
	output logic ref_o,
	output logic [fnd_pkg::FWD_DATA_W-1:0] odiv_word_o
);
	import fnd_pkg::*;
	logic [FWD_DATA_W-1:0] sub_q [8];
	////////////////////////////////////////
	// reference edges
	initial begin
		ref_o = 1'b0;
		#3;
		forever #HALF_NS ref_o = ~ref_o;
	end
	always @(posedge sys_clk_i) begin
		if (fwd_valid_i) begin
			sub_q[fwd_addr_i] <= fwd_data_i;
		end
	end
	assign odiv_word_o = sub_q[OSC_OUT_DIV_ADDR];
endmodule : fnd_ref_model

// [testbench.sv]
// Purpose: directed register-port test of the divider control block
// Assumes: reference period is ten system clocks
// Notes: expected ratios follow the 24-bit accumulator arithmetic
`timescale 1ns/1ps
module testbench;
	import fnd_pkg::*;
	logic sys_clk_i = 0;
	logic resetn_i = 0;
	logic reg_wr_i = 0;
	logic reg_rd_i = 0;
	logic [ADDR_W-1:0] reg_addr_i = '0;
	logic [DATA_W-1:0] reg_wdata_i = '0;
	logic [DATA_W-1:0] reg_rdata_o;
	logic ref_in_i, pd_tick_o, frac_mode_o, range_err_o, fwd_valid_o;
	logic [NDIV_W-1:0] ndiv_o;
	logic [FWD_ADDR_W-1:0] fwd_addr_o;
	logic [FWD_DATA_W-1:0] fwd_data_o, odiv_word;
	logic [ODIV_W-1:0] out_div_o;
	logic [19:0] n;
	int c;
	int n_mismatch = 0;
	int checks_done = 0;
	logic [4:0] ra [5] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h0C};
	logic [23:0] rv [5] = '{24'h00_0001, 24'h00_0019, 24'h00_0000, 24'h00_0082, 24'h00_0000};
	logic [23:0] rw [5] = '{24'h00_3FFF, 24'h07_FFFF, 24'hFF_FFFF, 24'h00_0FFF, 24'h00_3FFF};
	logic [8:0] fd [5] = '{9'h000, 9'h001, 9'h002, 9'h03E, 9'h03F};
	logic [5:0] eo [5] = '{6'h01, 6'h01, 6'h02, 6'h3E, 6'h3E};
	always #10 sys_clk_i = ~sys_clk_i;
	fnd_ctrl i_fnd_ctrl (.sys_clk_i, .resetn_i, .ref_in_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
		.reg_wdata_i, .reg_rdata_o, .pd_tick_o, .ndiv_o, .frac_mode_o, .range_err_o,
		.fwd_valid_o, .fwd_addr_o, .fwd_data_o, .out_div_o);
	fnd_ref_model i_fnd_ref_model (.sys_clk_i, .fwd_valid_i(fwd_valid_o),
		.fwd_addr_i(fwd_addr_o), .fwd_data_i(fwd_data_o), .ref_o(ref_in_i),
		.odiv_word_o(odiv_word));
	////////////////////////////////////////
	task automatic give_verdict();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(logic [4:0] a, logic [23:0] d);
		@(negedge sys_clk_i);
		reg_wr_i = 1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(negedge sys_clk_i);
		reg_wr_i = 0;
	endtask : wr
	task automatic rchk(logic [4:0] a, logic [23:0] e);
		@(negedge sys_clk_i);
		reg_rd_i = 1;
		reg_addr_i = a;
		@(negedge sys_clk_i);
		reg_rd_i = 0;
		chk("rdata", e, reg_rdata_o);
	endtask : rchk
	// ratio in force after the next compare strobe
	task automatic tick(output logic [19:0] r);
		int i;
		for (i = 0; i < 4000 && pd_tick_o !== 1'b1; i++) @(negedge sys_clk_i);
		if (i == 4000) begin
			n_mismatch++;
			give_verdict();
		end
		@(negedge sys_clk_i);
		r = ndiv_o;
	endtask : tick
	task automatic ticks_sum(int k, logic [23:0] e);
		logic [23:0] s;
		logic [19:0] r;
		s = '0;
		repeat (k) begin
			tick(r);
			s = s + r;
		end
		chk("sum", e, s);
	endtask : ticks_sum
	initial begin
		repeat (6) @(negedge sys_clk_i);
		resetn_i = 1;
		chk("ndiv", 25, ndiv_o);
		chk("out_div", 1, out_div_o);
		foreach (ra[i]) rchk(ra[i], rv[i]);
		wr(5'h01, 24'h00_1234);
		rchk(5'h01, 24'h00_0000);
		foreach (ra[i]) wr(ra[i], 24'hFF_FFFF);
		foreach (ra[i]) rchk(ra[i], rw[i]);
		wr(OFS_REF_DIV, 24'h00_0001);
		wr(OFS_MOD_CFG, 24'h00_0080);
		wr(OFS_INT, 24'h00_0010);
		tick(n);
		tick(n);
		chk("ndiv", 16, n);
		chk("fmode", 0, frac_mode_o);
		wr(OFS_INT, 24'h07_FFFF);
		tick(n);
		chk("ndiv", 24'h07_FFFF, n);
		wr(OFS_INT, 24'h00_000F);
		tick(n);
		chk("ndiv", 16, n);
		chk("range", 1, range_err_o);
		wr(OFS_EXACT, 24'h00_0000);
		wr(OFS_FRAC, 24'h40_0000);
		wr(OFS_MOD_CFG, 24'h00_0800);
		wr(OFS_INT, 24'h00_0013);
		tick(n);
		chk("ndiv", 20, n);
		chk("range", 1, range_err_o);
		chk("fmode", 1, frac_mode_o);
		wr(OFS_INT, 24'h00_0014);
		tick(n);
		chk("range", 0, range_err_o);
		ticks_sum(8, 24'h00_00A2);
		wr(OFS_MOD_CFG, 24'h00_0801);
		wr(OFS_FRAC, 24'h80_0000);
		tick(n);
		tick(n);
		chk("ndiv", 21, n);
		wr(OFS_MOD_CFG, 24'h00_0800);
		tick(n);
		tick(n);
		chk("ndiv", 20, n);
		wr(OFS_MOD_CFG, 24'h00_0803);
		tick(n);
		tick(n);
		chk("ndiv", 20, n);
		tick(n);
		chk("ndiv", 21, n);
		wr(OFS_MOD_CFG, 24'h00_0802);
		wr(OFS_INT, 24'h00_0014);
		wr(OFS_EXACT, 24'h00_0003);
		wr(OFS_FRAC, 24'h55_5556);
		tick(n);
		ticks_sum(9, 24'h00_00B7);
		wr(OFS_FRAC, 24'hAA_AAAB);
		tick(n);
		ticks_sum(9, 24'h00_00BA);
		foreach (fd[i]) begin
			wr(OFS_FWD, {12'h000, fd[i], 3'h2});
			chk("fwd_valid", 1, fwd_valid_o);
			chk("out_div", eo[i], out_div_o);
			// sink loads on the edge that samples the valid pulse
			@(negedge sys_clk_i);
			chk("sub_word", fd[i], odiv_word);
		end
		wr(OFS_FWD, 24'h00_002B);
		chk("fwd_addr", 3, fwd_addr_o);
		chk("fwd_data", 5, fwd_data_o);
		chk("out_div", 62, out_div_o);
		wr(OFS_REF_DIV, 24'h00_0003);
		tick(n);
		tick(n);
		for (c = 1; c < 99 && pd_tick_o !== 1'b1; c++) @(negedge sys_clk_i);
		chk("gap", 30, c);
		give_verdict();
	end
endmodule : testbench
